// ---- rtl/irs_pkg.sv ----
// Constants and types shared by the interrupt and reset sequencer
//
// Summary of operation
// - Soft trap instruction is taken regardless of mask flag; vectors through 3FFC/3FFD.
// - With mask clear, soft trap follows hardware requests pending before its fetch.
// - Mask flag blocks every hardware source; reset is never masked.
// - External request combines request pin with eight keyscan pins, pull-up gated.
// - Edge-only build: falling edges on pin or enabled keyscan pins raise request.
// - Edge-and-level build: low level or falling edge on pin or keyscan pins.
// - Sensitivity choice is a build-time parameter, not a software setting.
// - External request mask bit blocks all external requests besides the mask flag.
// - Branch-on-request-level sees pin level ORed with keyscan sources.
// - External request latched after falling edge; vectors through 3FFA/3FFB.
// - Modulator request when end-of-cycle flag and its enable are set; 3FF8/3FF9.
// - Timer wrap from all ones to zero with enable requests an interrupt.
// - Periodic interval with enable requests; both timer sources share 3FF6/3FF7.
// - Five reset sources merge into one internal reset for all peripherals.
// - Low external reset input holds the device in reset until it rises.
// - Only ends of external or watchdog reset relatch the operating mode.
// - Reset sequence starts at the first clock edge after external reset rises.
// - Low-power reset release waits 4064 cycles before the reset vector.
// - Among pending hardware requests, the highest vector address is served first.
// - Requests arriving while masked stay pending until the mask flag clears.
// - Core finishes instruction, stacks, sets mask, then acknowledges the vector.
package irs_pkg;

	localparam int          ADDR_W        = 14;
	localparam int          KEY_W         = 8;
	localparam int          SRC_W         = 4;

	// Low byte address of each vector pair
	localparam logic [13:0] VEC_RESET     = 14'h3ffe;
	localparam logic [13:0] VEC_SOFT_TRAP = 14'h3ffc;
	localparam logic [13:0] VEC_EXTERNAL  = 14'h3ffa;
	localparam logic [13:0] VEC_MODULATOR = 14'h3ff8;
	localparam logic [13:0] VEC_TIMER     = 14'h3ff6;

	// One-hot vector select positions
	localparam int          SEL_TIMER     = 0;
	localparam int          SEL_MODULATOR = 1;
	localparam int          SEL_EXTERNAL  = 2;
	localparam int          SEL_SOFT_TRAP = 3;

	localparam logic [7:0]  TIMER_ALL_ONES = 8'hff;
	localparam logic [7:0]  TIMER_ZERO     = 8'h00;

	// Stabilisation delay after low-power reset release, in clock cycles
	localparam logic [11:0] LP_STAB_CYCLES = 12'hfe0;
	localparam logic [11:0] LP_STAB_LAST   = LP_STAB_CYCLES - 12'h001;

	localparam logic        MODE_RESET_VALUE = 1'b0;

	typedef enum logic [4:0] {
		IRS_RST_HOLD   = 5'h01,
		IRS_RST_STAB   = 5'h02,
		IRS_RST_VECTOR = 5'h04,
		IRS_RST_RUN    = 5'h08,
		IRS_RST_SPARE  = 5'h10
	} irs_rst_state_t;

endpackage

// ---- rtl/irs_ext_request.sv ----
// External request latch for the request pin and keyscan pins
`timescale 1ns/1ps
module irs_ext_request #(
	parameter bit EDGE_AND_LEVEL = 1'b0
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Pins and configuration
	input  wire logic                      request_pin_n,
	input  wire logic [irs_pkg::KEY_W-1:0] keyscan_pins,
	input  wire logic [irs_pkg::KEY_W-1:0] keyscan_pullup_en,
	// Control from the sequencer
	input  wire logic                      clear,
	input  wire logic                      ack,
	// Status
	output logic                           pending,
	output logic                           level_any
);
	import irs_pkg::*;

	typedef struct packed {
		logic             pin_prev;
		logic [KEY_W-1:0] key_prev;
		logic             pending;
		logic             level_any;
	} irs_ext_state_t;

	irs_ext_state_t state;
	irs_ext_state_t next_state;

	logic [KEY_W-1:0] key_live;
	logic             pin_fall;
	logic             key_fall;
	logic             level_low;
	logic             set_req;

	always_comb begin
		next_state = state;
		key_live   = ~keyscan_pins & keyscan_pullup_en;
		pin_fall   = state.pin_prev & ~request_pin_n;
		key_fall   = |(state.key_prev & ~keyscan_pins & keyscan_pullup_en);
		level_low  = ~request_pin_n | (|key_live);
		if (EDGE_AND_LEVEL) begin
			set_req = pin_fall | key_fall | level_low;
		end else begin
			set_req = pin_fall | key_fall;
		end
		next_state.pin_prev  = request_pin_n;
		next_state.key_prev  = keyscan_pins;
		next_state.level_any = level_low;
		// A new edge in the ack cycle is kept
		if (clear) begin
			next_state.pending = 1'b0;
		end else begin
			next_state.pending = set_req | (state.pending & ~ack);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= '{pin_prev: 1'b1, key_prev: '1, pending: 1'b0, level_any: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign pending   = state.pending;
	assign level_any = state.level_any;

endmodule

// ---- rtl/irs_core.sv ----
// Interrupt collection, priority and reset sequencing for the CPU core
`timescale 1ns/1ps
module irs_core #(
	parameter bit EDGE_AND_LEVEL = 1'b0
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Reset sources
	input  wire logic                       ext_reset_n,
	input  wire logic                       low_power_reset_in_n,
	input  wire logic                       por_reset,
	input  wire logic                       watchdog_reset,
	input  wire logic                       illegal_addr_reset,
	input  wire logic                       mode_strap,
	// Core status and handshake
	input  wire logic                       condition_flags_mask,
	input  wire logic                       instr_fetch,
	input  wire logic                       soft_trap_instruction,
	input  wire logic                       irq_ack,
	// External request pins
	input  wire logic                       request_pin_n,
	input  wire logic [irs_pkg::KEY_W-1:0]  keyscan_pins,
	input  wire logic [irs_pkg::KEY_W-1:0]  keyscan_pullup_en,
	// Carrier modulator
	input  wire logic                       external_request_mask,
	input  wire logic                       end_of_cycle_flag,
	input  wire logic                       end_of_cycle_irq_enable,
	// Core timer
	input  wire logic [7:0]                 timer_value,
	input  wire logic                       timer_wrap_irq_enable,
	input  wire logic                       periodic_elapsed,
	input  wire logic                       periodic_irq_enable,
	// Requests to the core
	output logic                            irq_request,
	output logic [irs_pkg::SRC_W-1:0]       vector_sel,
	output logic [irs_pkg::ADDR_W-1:0]      vector_addr,
	output logic                            request_level_active,
	// Reset outputs
	output logic                            internal_reset,
	output logic                            reset_vector_fetch,
	output logic                            op_mode
);
	import irs_pkg::*;

	typedef struct packed {
		irs_rst_state_t    rst_state;
		logic [11:0]       stab_cnt;
		logic              ext_seen;
		logic              lp_seen;
		logic              wdog_seen;
		logic              op_mode;
		logic              internal_reset;
		logic              reset_vector_fetch;
		logic [7:0]        timer_prev;
		logic              timer_pending;
		logic              trap_pending;
		logic              hw_before_trap;
		logic              irq_request;
		logic [SRC_W-1:0]  vector_sel;
		logic [ADDR_W-1:0] vector_addr;
		logic              req_level;
	} irs_core_state_t;

	irs_core_state_t state;
	irs_core_state_t next_state;

	logic ext_pending;
	logic ext_level;
	logic ext_clear;
	logic ext_ack;
	logic any_reset_src;
	logic other_src;
	logic in_run;
	logic timer_wrap;
	logic timer_set;
	logic timer_ack;
	logic trap_ack;
	logic ext_req;
	logic mod_req;
	logic tim_req;
	logic hw_any;
	logic [SRC_W-1:0] pick;

	// Hardware sources by vector address, highest first
	function automatic logic [SRC_W-1:0] hw_priority(input logic ext, input logic modu, input logic tim);
		logic [SRC_W-1:0] sel;
		sel = '0;
		if (ext) begin
			sel[SEL_EXTERNAL] = 1'b1;
		end else if (modu) begin
			sel[SEL_MODULATOR] = 1'b1;
		end else if (tim) begin
			sel[SEL_TIMER] = 1'b1;
		end
		return sel;
	endfunction

	function automatic logic [ADDR_W-1:0] sel_to_vector(input logic [SRC_W-1:0] sel);
		logic [ADDR_W-1:0] addr;
		addr = VEC_TIMER;
		if (sel[SEL_SOFT_TRAP]) begin
			addr = VEC_SOFT_TRAP;
		end else if (sel[SEL_EXTERNAL]) begin
			addr = VEC_EXTERNAL;
		end else if (sel[SEL_MODULATOR]) begin
			addr = VEC_MODULATOR;
		end
		return addr;
	endfunction

	// Pending latches cleared while the device sits in reset
	assign ext_clear = ~in_run;
	assign ext_ack   = irq_ack & state.vector_sel[SEL_EXTERNAL];

	irs_ext_request #(
		.EDGE_AND_LEVEL (EDGE_AND_LEVEL)
	) u_ext_request (
		.clk               (clk),
		.rst_n             (rst_n),
		.request_pin_n     (request_pin_n),
		.keyscan_pins      (keyscan_pins),
		.keyscan_pullup_en (keyscan_pullup_en),
		.clear             (ext_clear),
		.ack               (ext_ack),
		.pending           (ext_pending),
		.level_any         (ext_level)
	);

	always_comb begin
		next_state = state;

		// Reset source merge
		other_src     = por_reset | watchdog_reset | illegal_addr_reset | ~ext_reset_n;
		any_reset_src = other_src | ~low_power_reset_in_n;
		next_state.reset_vector_fetch = 1'b0;

		case (state.rst_state)
			IRS_RST_HOLD: begin
				next_state.ext_seen  = state.ext_seen | ~ext_reset_n;
				next_state.lp_seen   = state.lp_seen | ~low_power_reset_in_n;
				next_state.wdog_seen = state.wdog_seen | watchdog_reset;
				next_state.stab_cnt  = '0;
				// Held while any source stays active
				if (!any_reset_src) begin
					if (next_state.lp_seen) begin
						next_state.rst_state = IRS_RST_STAB;
					end else begin
						next_state.rst_state = IRS_RST_VECTOR;
					end
				end
			end
			IRS_RST_STAB: begin
				next_state.ext_seen  = state.ext_seen | ~ext_reset_n;
				next_state.wdog_seen = state.wdog_seen | watchdog_reset;
				if (!low_power_reset_in_n) begin
					next_state.rst_state = IRS_RST_HOLD;
				end else if (state.stab_cnt == LP_STAB_LAST) begin
					next_state.lp_seen = 1'b0;
					// Other sources still active extend the reset
					if (other_src) begin
						next_state.rst_state = IRS_RST_HOLD;
					end else begin
						next_state.rst_state = IRS_RST_VECTOR;
					end
				end else begin
					next_state.stab_cnt = state.stab_cnt + 12'h001;
				end
			end
			IRS_RST_VECTOR: begin
				if (any_reset_src) begin
					next_state.rst_state = IRS_RST_HOLD;
				end else begin
					next_state.reset_vector_fetch = 1'b1;
					// Mode follows only the end of external or watchdog reset
					if (state.ext_seen || state.wdog_seen) begin
						next_state.op_mode = mode_strap;
					end
					next_state.ext_seen  = 1'b0;
					next_state.wdog_seen = 1'b0;
					next_state.lp_seen   = 1'b0;
					next_state.rst_state = IRS_RST_RUN;
				end
			end
			IRS_RST_RUN: begin
				// Reset is never masked
				if (any_reset_src) begin
					next_state.rst_state = IRS_RST_HOLD;
				end
			end
			default: begin
				next_state.rst_state = IRS_RST_HOLD;
			end
		endcase

		next_state.internal_reset = (next_state.rst_state != IRS_RST_RUN);
		in_run = (state.rst_state == IRS_RST_RUN);

		// Timer sources
		timer_wrap = (state.timer_prev == TIMER_ALL_ONES) && (timer_value == TIMER_ZERO);
		timer_set  = (timer_wrap & timer_wrap_irq_enable)
			| (periodic_elapsed & periodic_irq_enable);
		timer_ack  = irq_ack & state.vector_sel[SEL_TIMER];
		trap_ack   = irq_ack & state.vector_sel[SEL_SOFT_TRAP];
		next_state.timer_prev = timer_value;

		// Set wins over acknowledge; held while masked
		if (!in_run) begin
			next_state.timer_pending = 1'b0;
		end else begin
			next_state.timer_pending = timer_set | (state.timer_pending & ~timer_ack);
		end

		if (!in_run) begin
			next_state.trap_pending = 1'b0;
		end else begin
			next_state.trap_pending = soft_trap_instruction | (state.trap_pending & ~trap_ack);
		end

		// Masked request terms
		ext_req = ext_pending & ~external_request_mask & ~condition_flags_mask;
		mod_req = end_of_cycle_flag & end_of_cycle_irq_enable & ~condition_flags_mask;
		tim_req = state.timer_pending & ~condition_flags_mask;
		hw_any  = ext_req | mod_req | tim_req;

		// Snapshot of hardware requests at each instruction fetch
		if (!in_run) begin
			next_state.hw_before_trap = 1'b0;
		end else if (instr_fetch) begin
			next_state.hw_before_trap = hw_any;
		end else if (irq_ack && !state.vector_sel[SEL_SOFT_TRAP]) begin
			next_state.hw_before_trap = 1'b0;
		end

		// Soft trap ignores the mask but yields to earlier hardware requests
		pick = hw_priority(ext_req, mod_req, tim_req);
		if (state.trap_pending && !trap_ack && !(hw_any && state.hw_before_trap)) begin
			pick = '0;
			pick[SEL_SOFT_TRAP] = 1'b1;
		end

		// Request held until the core acknowledges after stacking
		if (!in_run || irq_ack) begin
			next_state.irq_request = 1'b0;
			next_state.vector_sel  = '0;
		end else begin
			next_state.irq_request = |pick;
			next_state.vector_sel  = pick;
		end

		if (next_state.reset_vector_fetch || !in_run) begin
			next_state.vector_addr = VEC_RESET;
		end else begin
			next_state.vector_addr = sel_to_vector(next_state.vector_sel);
		end

		next_state.req_level = ext_level;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state.rst_state          <= IRS_RST_HOLD;
			state.stab_cnt           <= '0;
			state.ext_seen           <= 1'b0;
			state.lp_seen            <= 1'b0;
			state.wdog_seen          <= 1'b0;
			state.op_mode            <= MODE_RESET_VALUE;
			state.internal_reset     <= 1'b1;
			state.reset_vector_fetch <= 1'b0;
			state.timer_prev         <= TIMER_ZERO;
			state.timer_pending      <= 1'b0;
			state.trap_pending       <= 1'b0;
			state.hw_before_trap     <= 1'b0;
			state.irq_request        <= 1'b0;
			state.vector_sel         <= '0;
			state.vector_addr        <= VEC_RESET;
			state.req_level          <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign irq_request          = state.irq_request;
	assign vector_sel           = state.vector_sel;
	assign vector_addr          = state.vector_addr;
	assign request_level_active = state.req_level;
	assign internal_reset       = state.internal_reset;
	assign reset_vector_fetch   = state.reset_vector_fetch;
	assign op_mode              = state.op_mode;

endmodule

// ---- verification/irs_core_sva.sv ----
// Port checker for the interrupt and reset sequencer
`timescale 1ns/1ps
module irs_core_sva (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       rst_n,
	// Inputs watched
	input wire logic                       ext_reset_n,
	input wire logic                       low_power_reset_in_n,
	input wire logic                       condition_flags_mask,
	input wire logic                       irq_ack,
	input wire logic                       request_pin_n,
	input wire logic [irs_pkg::KEY_W-1:0]  keyscan_pins,
	input wire logic [irs_pkg::KEY_W-1:0]  keyscan_pullup_en,
	// Outputs watched
	input wire logic                       irq_request,
	input wire logic [irs_pkg::SRC_W-1:0]  vector_sel,
	input wire logic [irs_pkg::ADDR_W-1:0] vector_addr,
	input wire logic                       request_level_active,
	input wire logic                       internal_reset,
	input wire logic                       reset_vector_fetch,
	input wire logic                       op_mode
);
	import irs_pkg::*;
	logic [12:0] stab_cnt;
	logic        lp_seen;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Saturates so a stuck sequencer cannot wrap the count
	always_ff @(posedge clk) begin
		if (!rst_n || !low_power_reset_in_n) begin
			stab_cnt <= 13'h0000;
		end else if (internal_reset && stab_cnt != 13'h1fff) begin
			stab_cnt <= stab_cnt + 13'h0001;
		end
		if (!rst_n) begin
			lp_seen <= 1'h0;
		end else if (!low_power_reset_in_n) begin
			lp_seen <= 1'h1;
		end else if (reset_vector_fetch) begin
			lp_seen <= 1'h0;
		end
	end
	AST_TRAP_VEC: assert property (vector_sel[SEL_SOFT_TRAP] |-> vector_addr == VEC_SOFT_TRAP)
		else $error("soft trap vector address wrong");
	AST_EXT_VEC: assert property (vector_sel[SEL_EXTERNAL] |-> vector_addr == VEC_EXTERNAL)
		else $error("external vector address wrong");
	AST_MOD_VEC: assert property (vector_sel[SEL_MODULATOR] |-> vector_addr == VEC_MODULATOR)
		else $error("modulator vector address wrong");
	AST_TMR_VEC: assert property (vector_sel[SEL_TIMER] |-> vector_addr == VEC_TIMER)
		else $error("timer vector address wrong");
	AST_MASK_BLOCK: assert property ($rose(irq_request) && !vector_sel[SEL_SOFT_TRAP]
		|-> !$past(condition_flags_mask)) else $error("hardware request offered while masked");
	AST_ACK_CLEAR: assert property (irq_ack && irq_request |=> !irq_request)
		else $error("request not withdrawn after acknowledge");
	AST_RST_HOLD: assert property (!ext_reset_n |=> internal_reset)
		else $error("external reset did not hold internal reset");
	AST_RST_START: assert property ($rose(ext_reset_n) && low_power_reset_in_n && internal_reset
		|-> ##[1:2] reset_vector_fetch) else $error("reset sequence late after release");
	AST_LP_STAB: assert property (reset_vector_fetch && lp_seen |-> stab_cnt >= 13'h0fe0)
		else $error("reset vector before stabilisation count");
	AST_MODE_KEEP: assert property ($changed(op_mode) |-> reset_vector_fetch)
		else $error("operating mode changed outside reset end");
	// Level passes the latch and then the output register, so it trails the pins by two edges
	AST_LEVEL_OR: assert property ($past(rst_n) && $past(rst_n, 2) |-> request_level_active ==
		$past(!request_pin_n || |(~keyscan_pins & keyscan_pullup_en), 2)) else $error("request level wrong");
endmodule

// ---- verification/irs_cpu_model.sv ----
// Behavioural CPU core: opcode fetch pulses and interrupt acknowledge
`timescale 1ns/1ps
module irs_cpu_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Bench control
	input  wire logic       auto_ack,
	input  wire logic [3:0] ack_wait,
	// Sequencer side
	input  wire logic       irq_request,
	output logic            irq_ack = 1'h0,
	output logic            instr_fetch = 1'h0
);
	logic [3:0] wait_cnt = 4'h0;
	logic [1:0] fetch_cnt = 2'h0;
	// Falling edge drive keeps every pulse whole around the sampling edge
	always @(negedge clk) begin
		irq_ack <= 1'h0;
		fetch_cnt <= fetch_cnt + 2'h1;
		instr_fetch <= rst_n && fetch_cnt == 2'h3;
		// Wait stands for instruction end and stacking
		if (!rst_n || !irq_request || !auto_ack || irq_ack) begin
			wait_cnt <= 4'h0;
		end else if (wait_cnt == ack_wait) begin
			irq_ack <= 1'h1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

// ---- verification/irs_core_tb.sv ----
// Self-checking bench for the interrupt and reset sequencer
`timescale 1ns/1ps
module irs_core_tb;
	import irs_pkg::*;
	typedef struct packed {
		logic       msk, emsk, pin_n;
		logic [7:0] keys, pu;
		logic       eoc, eoce, wrap, wen, per, pen;
		logic [3:0] sel;
	} irs_row_t;
	logic        clk = 1'h0, rst_n = 1'h0, ext_reset_n = 1'h1, low_power_reset_in_n = 1'h1;
	logic        por_reset = 1'h0, watchdog_reset = 1'h0, illegal_addr_reset = 1'h0, mode_strap = 1'h0;
	logic        condition_flags_mask = 1'h0, soft_trap_instruction = 1'h0, request_pin_n = 1'h1;
	logic [7:0]  keyscan_pins = 8'hff, keyscan_pullup_en = 8'h00, timer_value = 8'h10;
	logic        external_request_mask = 1'h0, end_of_cycle_flag = 1'h0, end_of_cycle_irq_enable = 1'h0;
	logic        timer_wrap_irq_enable = 1'h0, periodic_elapsed = 1'h0, periodic_irq_enable = 1'h0;
	logic        auto_ack = 1'h0, instr_fetch, irq_ack, irq_request, request_level_active;
	logic        internal_reset, reset_vector_fetch, op_mode;
	logic [3:0]  vector_sel, ack_wait = 4'h2;
	logic [13:0] vector_addr;
	logic        lvl_req;
	logic [3:0]  lvl_sel;
	int          err_total = 0, tests_run = 0, n;
	irs_row_t    rows [10];
	always #50 clk = ~clk;
	irs_core i_dut (.clk, .rst_n, .ext_reset_n, .low_power_reset_in_n, .por_reset, .watchdog_reset,
		.illegal_addr_reset, .mode_strap, .condition_flags_mask, .instr_fetch, .soft_trap_instruction,
		.irq_ack, .request_pin_n, .keyscan_pins, .keyscan_pullup_en, .external_request_mask,
		.end_of_cycle_flag, .end_of_cycle_irq_enable, .timer_value, .timer_wrap_irq_enable,
		.periodic_elapsed, .periodic_irq_enable, .irq_request, .vector_sel, .vector_addr,
		.request_level_active, .internal_reset, .reset_vector_fetch, .op_mode);
	// Edge-and-level build on the same inputs; the core model watches only the edge-only copy's request, but its acknowledge reaches both
	irs_core #(.EDGE_AND_LEVEL(1'b1)) i_dut_lvl (.clk, .rst_n, .ext_reset_n, .low_power_reset_in_n, .por_reset,
		.watchdog_reset, .illegal_addr_reset, .mode_strap, .condition_flags_mask, .instr_fetch,
		.soft_trap_instruction, .irq_ack, .request_pin_n, .keyscan_pins, .keyscan_pullup_en,
		.external_request_mask, .end_of_cycle_flag, .end_of_cycle_irq_enable, .timer_value,
		.timer_wrap_irq_enable, .periodic_elapsed, .periodic_irq_enable, .irq_request(lvl_req),
		.vector_sel(lvl_sel), .vector_addr(), .request_level_active(), .internal_reset(),
		.reset_vector_fetch(), .op_mode());
	irs_cpu_model i_cpu (.clk, .rst_n, .auto_ack, .ack_wait, .irq_request, .irq_ack, .instr_fetch);
	task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Sources idle and unmasked, core serves whatever is left
	task automatic drain();
		request_pin_n = 1'h1;
		keyscan_pins = 8'hff;
		end_of_cycle_flag = 1'h0;
		condition_flags_mask = 1'h0;
		external_request_mask = 1'h0;
		auto_ack = 1'h1;
		cyc(40);
		chk("idle", irq_request, 1'h0);
		auto_ack = 1'h0;
	endtask
	task automatic rst_src(input logic [3:0] src, input logic strap, input logic mode);
		mode_strap = strap;
		ext_reset_n = !src[3];
		{por_reset, watchdog_reset, illegal_addr_reset} = src[2:0];
		cyc(3);
		chk("held", internal_reset, 1'h1);
		ext_reset_n = 1'h1;
		{por_reset, watchdog_reset, illegal_addr_reset} = 3'h0;
		n = 0;
		while (!reset_vector_fetch && n < 8) begin
			cyc(1);
			n++;
		end
		chk("start", n <= 2, 1'h1);
		chk("mode", op_mode, mode);
		cyc(2);
	endtask
	initial begin : watchdog
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	initial begin
		rows = '{'{1'h0, 1'h0, 1'h0, 8'hff, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'h4},
			'{1'h0, 1'h0, 1'h1, 8'hf7, 8'h08, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'h4},
			'{1'h0, 1'h0, 1'h1, 8'hf7, 8'hf7, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0},
			'{1'h0, 1'h1, 1'h0, 8'hff, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0},
			'{1'h0, 1'h0, 1'h1, 8'hff, 8'h00, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 4'h2},
			'{1'h0, 1'h0, 1'h1, 8'hff, 8'h00, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0},
			'{1'h0, 1'h0, 1'h1, 8'hff, 8'h00, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 4'h1},
			'{1'h0, 1'h0, 1'h1, 8'hff, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 4'h1},
			'{1'h1, 1'h0, 1'h0, 8'hff, 8'h00, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 4'h0},
			'{1'h0, 1'h0, 1'h0, 8'hff, 8'h00, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 4'h4}};
		repeat (8) @(posedge clk);
		@(negedge clk) rst_n = 1'h1;
		cyc(4);
		chk("boot", internal_reset, 1'h0);
		foreach (rows[i]) begin
			condition_flags_mask = rows[i].msk;
			external_request_mask = rows[i].emsk;
			keyscan_pullup_en = rows[i].pu;
			end_of_cycle_irq_enable = rows[i].eoce;
			timer_wrap_irq_enable = rows[i].wen;
			periodic_irq_enable = rows[i].pen;
			timer_value = rows[i].wrap ? 8'hff : 8'h10;
			cyc(1);
			request_pin_n = rows[i].pin_n;
			keyscan_pins = rows[i].keys;
			end_of_cycle_flag = rows[i].eoc;
			periodic_elapsed = rows[i].per;
			timer_value = rows[i].wrap ? 8'h00 : 8'h11;
			cyc(1);
			periodic_elapsed = 1'h0;
			cyc(3);
			chk("sel", vector_sel, rows[i].sel);
			chk("req", irq_request, |rows[i].sel);
			chk("lvl", request_level_active, !rows[i].pin_n || |(~rows[i].keys & rows[i].pu));
			drain();
		end
		ack_wait = 4'h9;
		condition_flags_mask = 1'h1;
		soft_trap_instruction = 1'h1;
		cyc(1);
		soft_trap_instruction = 1'h0;
		cyc(3);
		chk("trap", vector_sel, 4'h8);
		drain();
		end_of_cycle_flag = 1'h1;
		cyc(6);
		soft_trap_instruction = 1'h1;
		cyc(1);
		soft_trap_instruction = 1'h0;
		cyc(3);
		chk("order", vector_sel, 4'h2);
		drain();
		rst_src(4'h8, 1'h1, 1'h1);
		rst_src(4'h4, 1'h0, 1'h1);
		rst_src(4'h2, 1'h0, 1'h0);
		rst_src(4'h1, 1'h1, 1'h0);
		request_pin_n = 1'h0;
		auto_ack = 1'h1;
		cyc(20);
		chk("edge_once", irq_request, 1'h0);
		chk("lvl_again", lvl_req, 1'h1);
		chk("lvl_sel", lvl_sel, 4'h4);
		drain();
		low_power_reset_in_n = 1'h0;
		cyc(3);
		chk("lp_held", internal_reset, 1'h1);
		low_power_reset_in_n = 1'h1;
		n = 0;
		while (!reset_vector_fetch && n < 5000) begin
			cyc(1);
			n++;
		end
		chk("lp_delay", n >= 4064 && n <= 4067, 1'h1);
		print_verdict();
	end
endmodule
bind irs_core irs_core_sva i_sva (.clk, .rst_n, .ext_reset_n, .low_power_reset_in_n, .condition_flags_mask,
	.irq_ack, .request_pin_n, .keyscan_pins, .keyscan_pullup_en, .irq_request, .vector_sel, .vector_addr,
	.request_level_active, .internal_reset, .reset_vector_fetch, .op_mode);
